// File: verilog/aspi_top.sv
/*
 * aspi_top: converter, supply monitor and two port interrupt registers
 * with grouped vector requests to the processor core.
 * assumes: event inputs synchronous to clk_sys_i; the core pulses
 * irq_service_entry_i when it enters an interrupt service.
 */
// Chosen here: the AXI4-Lite register port.
// Notes on behaviour
// - converter enable at bit 16, resets 0, gates converter interrupt
// - converter flag bit 0 read-only, cleared by reading the result register
// - converter request reads at bit 8; bits 15..8 mask on writes
// - brown-out enable at bit 17, resets 0
// - low-voltage enable at bit 16, resets 0
// - low-voltage flag bit 0 set by event, resets 0, cleared by writing 0
// - brown-out flag bit 1 set by event, cleared by writing 0
// - supply requests read at bits 9 and 8; bits 15..8 mask on writes
// - port one pin enables at bits 23..16, reset 0
// - port one requests at bits 15..8, one per pin
// - port one pin flags bits 7..0 set by events, cleared by writing 0
// - port two pin enables at bits 23..16, reset 0
// - port two requests at bits 15..8, one per pin
// - port two pin flags bits 7..0 set by events, cleared by writing 0
// - port registers: bits 15..8 mask on write, requests on read
// - nothing reaches the core without global enable; service entry clears it
// - vectors two to five per group; equal level served lowest vector first
`timescale 1ns/1ps
module aspi_top
	import aspi_pkg::*;
(
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	// axi4-lite write
	input wire logic [ASPI_ADDR_W-1:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [ASPI_DATA_W-1:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	// axi4-lite read
	input wire logic [ASPI_ADDR_W-1:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [ASPI_DATA_W-1:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	// interrupt events
	input wire logic conversion_done_i,
	input wire logic conversion_result_read_i,
	input wire logic low_volt_comparator_out_i,
	input wire logic brownout_two_event_i,
	input wire logic [7:0] port_one_pin_event_i,
	input wire logic [7:0] port_two_pin_event_i,
	// core side
	input wire logic irq_service_entry_i,
	output logic [3:0] vector_request_o,
	output logic [3:0] vector_select_o,
	output logic global_irq_enable_o
);

	typedef struct packed {
		logic global_irq_enable;
		logic [3:0] vreq;
		logic [3:0] vsel;
	} aspi_top_state_t;

	aspi_top_state_t st_ff;
	aspi_top_state_t nxt_st;

	logic wr;
	logic [ASPI_ADDR_W-1:0] wr_addr;
	logic [ASPI_DATA_W-1:0] wr_data;
	logic [3:0] wr_strb;
	logic wr_ok;
	logic rd;
	logic [ASPI_ADDR_W-1:0] rd_addr;
	logic [ASPI_DATA_W-1:0] rd_data;
	logic rd_ok;

	logic [3:0] grp_wr;
	logic [7:0] wmask;
	logic [7:0] wenmask;
	logic [7:0] wen;
	logic [7:0] wflag;

	logic [0:0] adc_en, adc_flag, adc_req;
	logic [1:0] sup_en, sup_flag, sup_req;
	logic [7:0] pt1_en, pt1_flag, pt1_req;
	logic [7:0] pt2_en, pt2_flag, pt2_req;
	logic [3:0] grp_req;

	aspi_axil_slave u_bus (
		.clk_sys_i(clk_sys_i),
		.resetn_i(resetn_i),
		.s_axi_awaddr_i(s_axi_awaddr_i),
		.s_axi_awvalid_i(s_axi_awvalid_i),
		.s_axi_awready_o(s_axi_awready_o),
		.s_axi_wdata_i(s_axi_wdata_i),
		.s_axi_wstrb_i(s_axi_wstrb_i),
		.s_axi_wvalid_i(s_axi_wvalid_i),
		.s_axi_wready_o(s_axi_wready_o),
		.s_axi_bresp_o(s_axi_bresp_o),
		.s_axi_bvalid_o(s_axi_bvalid_o),
		.s_axi_bready_i(s_axi_bready_i),
		.s_axi_araddr_i(s_axi_araddr_i),
		.s_axi_arvalid_i(s_axi_arvalid_i),
		.s_axi_arready_o(s_axi_arready_o),
		.s_axi_rdata_o(s_axi_rdata_o),
		.s_axi_rresp_o(s_axi_rresp_o),
		.s_axi_rvalid_o(s_axi_rvalid_o),
		.s_axi_rready_i(s_axi_rready_i),
		.wr_o(wr),
		.wr_addr_o(wr_addr),
		.wr_data_o(wr_data),
		.wr_strb_o(wr_strb),
		.wr_ok_i(wr_ok),
		.rd_o(rd),
		.rd_addr_o(rd_addr),
		.rd_data_i(rd_data),
		.rd_ok_i(rd_ok)
	);

	// each mask sits eight bits above what it guards; an unwritten mask lane changes nothing
	assign wmask = wr_strb[1] ? wr_data[ASPI_REQ_LSB +: ASPI_FIELD_W] : 8'h00;
	assign wenmask = wr_strb[3] ? wr_data[ASPI_MASK_LSB +: ASPI_FIELD_W] : 8'h00;
	assign wen = wr_data[ASPI_EN_LSB +: ASPI_FIELD_W];
	assign wflag = wr_data[ASPI_FLAG_LSB +: ASPI_FIELD_W];

	always_comb
	begin
		grp_wr = 4'h0;
		wr_ok = 1'b1;
		if (wr)
		begin
			case (wr_addr)
				ASPI_OFS_ADC: grp_wr[ASPI_G_ADC] = 1'b1;
				ASPI_OFS_SUP: grp_wr[ASPI_G_SUP] = 1'b1;
				ASPI_OFS_PT1: grp_wr[ASPI_G_PT1] = 1'b1;
				ASPI_OFS_PT2: grp_wr[ASPI_G_PT2] = 1'b1;
				ASPI_OFS_GIE: wr_ok = 1'b1;
				default: wr_ok = 1'b0;
			endcase
		end
	end

	// converter flag is read-only: only the result read clears it
	aspi_group #(.WIDTH(1), .FLAG_RST(1'b0), .FLAG_SW_CLEAR(1'b0)) u_adc (
		.clk_sys_i(clk_sys_i),
		.resetn_i(resetn_i),
		.wr_i(grp_wr[ASPI_G_ADC]),
		.wr_en_mask_i(wenmask[0:0]),
		.wr_mask_i(wmask[0:0]),
		.wr_en_i(wen[0:0]),
		.wr_flag_i(wflag[0:0]),
		.event_i(conversion_done_i),
		.hw_clear_i(conversion_result_read_i),
		.enable_o(adc_en),
		.flag_o(adc_flag),
		.request_o(adc_req)
	);

	aspi_group #(.WIDTH(2), .FLAG_RST({ASPI_RST_BOR_FLAG, 1'b0})) u_sup (
		.clk_sys_i(clk_sys_i),
		.resetn_i(resetn_i),
		.wr_i(grp_wr[ASPI_G_SUP]),
		.wr_en_mask_i(wenmask[1:0]),
		.wr_mask_i(wmask[1:0]),
		.wr_en_i(wen[1:0]),
		.wr_flag_i(wflag[1:0]),
		.event_i({brownout_two_event_i, low_volt_comparator_out_i}),
		.hw_clear_i(1'b0),
		.enable_o(sup_en),
		.flag_o(sup_flag),
		.request_o(sup_req)
	);

	aspi_group #(.WIDTH(8), .FLAG_RST(ASPI_RST_FLAG)) u_pt1 (
		.clk_sys_i(clk_sys_i),
		.resetn_i(resetn_i),
		.wr_i(grp_wr[ASPI_G_PT1]),
		.wr_en_mask_i(wenmask),
		.wr_mask_i(wmask),
		.wr_en_i(wen),
		.wr_flag_i(wflag),
		.event_i(port_one_pin_event_i),
		.hw_clear_i(1'b0),
		.enable_o(pt1_en),
		.flag_o(pt1_flag),
		.request_o(pt1_req)
	);

	aspi_group #(.WIDTH(8), .FLAG_RST(ASPI_RST_FLAG)) u_pt2 (
		.clk_sys_i(clk_sys_i),
		.resetn_i(resetn_i),
		.wr_i(grp_wr[ASPI_G_PT2]),
		.wr_en_mask_i(wenmask),
		.wr_mask_i(wmask),
		.wr_en_i(wen),
		.wr_flag_i(wflag),
		.event_i(port_two_pin_event_i),
		.hw_clear_i(1'b0),
		.enable_o(pt2_en),
		.flag_o(pt2_flag),
		.request_o(pt2_req)
	);

	// read mux; mask byte always reads zero
	always_comb
	begin
		rd_data = '0;
		rd_ok = 1'b1;
		case (rd_addr)
			ASPI_OFS_ADC:
			begin
				rd_data[ASPI_EN_LSB] = adc_en[0];
				rd_data[ASPI_REQ_LSB] = adc_req[0];
				rd_data[ASPI_FLAG_LSB] = adc_flag[0];
			end
			ASPI_OFS_SUP:
			begin
				rd_data[ASPI_EN_LSB +: 2] = sup_en;
				rd_data[ASPI_REQ_LSB +: 2] = sup_req;
				rd_data[ASPI_FLAG_LSB +: 2] = sup_flag;
			end
			ASPI_OFS_PT1:
			begin
				rd_data[ASPI_EN_LSB +: ASPI_FIELD_W] = pt1_en;
				rd_data[ASPI_REQ_LSB +: ASPI_FIELD_W] = pt1_req;
				rd_data[ASPI_FLAG_LSB +: ASPI_FIELD_W] = pt1_flag;
			end
			ASPI_OFS_PT2:
			begin
				rd_data[ASPI_EN_LSB +: ASPI_FIELD_W] = pt2_en;
				rd_data[ASPI_REQ_LSB +: ASPI_FIELD_W] = pt2_req;
				rd_data[ASPI_FLAG_LSB +: ASPI_FIELD_W] = pt2_flag;
			end
			ASPI_OFS_GIE:
				rd_data[ASPI_GIE_BIT] = st_ff.global_irq_enable;
			default:
				rd_ok = 1'b0;
		endcase
	end

	assign grp_req[ASPI_G_ADC] = |adc_req;
	assign grp_req[ASPI_G_SUP] = |sup_req;
	assign grp_req[ASPI_G_PT1] = |pt1_req;
	assign grp_req[ASPI_G_PT2] = |pt2_req;

	always_comb
	begin
		nxt_st = st_ff;
		if (wr && wr_addr == ASPI_OFS_GIE && wr_strb[0])
			nxt_st.global_irq_enable = wr_data[ASPI_GIE_BIT];
		// service entry wins over a software set in the same cycle
		if (irq_service_entry_i)
			nxt_st.global_irq_enable = 1'b0;
		nxt_st.vreq = st_ff.global_irq_enable ? grp_req : 4'h0;
		nxt_st.vsel = 4'h0;
		// lowest vector first among simultaneous requests
		for (int i = 0; i < 4; i++)
		begin
			if (nxt_st.vreq[i] && nxt_st.vsel == 4'h0)
				nxt_st.vsel[i] = 1'b1;
		end
	end

	always_ff @(posedge clk_sys_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			st_ff.global_irq_enable <= ASPI_RST_GIE;
			st_ff.vreq <= 4'h0;
			st_ff.vsel <= 4'h0;
		end
		else
			st_ff <= nxt_st;
	end

	assign vector_request_o = st_ff.vreq;
	assign vector_select_o = st_ff.vsel;
	assign global_irq_enable_o = st_ff.global_irq_enable;

endmodule

// File: verilog/aspi_pkg.sv
/*
 * aspi_pkg: register map, field positions and reset values of the
 * converter, supply monitor and port interrupt registers.
 * assumes: a 32-bit AXI4-Lite register bus with byte addresses.
 */
package aspi_pkg;

	localparam int ASPI_ADDR_W = 8;
	localparam int ASPI_DATA_W = 32;

	// register byte offsets
	localparam logic [7:0] ASPI_OFS_ADC = 8'h08;
	localparam logic [7:0] ASPI_OFS_SUP = 8'h0C;
	localparam logic [7:0] ASPI_OFS_PT1 = 8'h10;
	localparam logic [7:0] ASPI_OFS_PT2 = 8'h14;
	localparam logic [7:0] ASPI_OFS_GIE = 8'h18;

	// field positions
	localparam int ASPI_FLAG_LSB = 0;
	localparam int ASPI_REQ_LSB = 8;
	localparam int ASPI_EN_LSB = 16;
	localparam int ASPI_MASK_LSB = 24;
	localparam int ASPI_FIELD_W = 8;
	localparam int ASPI_GIE_BIT = 0;

	// reset values
	localparam logic [7:0] ASPI_RST_EN = 8'h00;
	localparam logic [7:0] ASPI_RST_FLAG = 8'h00;
	// brown-out flag has no defined reset; zero is chosen
	localparam logic ASPI_RST_BOR_FLAG = 1'b0;
	localparam logic ASPI_RST_GIE = 1'b0;

	// implemented bits per group
	localparam logic [7:0] ASPI_ADC_BITS = 8'h01;
	localparam logic [7:0] ASPI_SUP_BITS = 8'h03;
	localparam logic [7:0] ASPI_PT_BITS = 8'hFF;

	localparam logic [1:0] ASPI_RESP_OKAY = 2'b00;
	localparam logic [1:0] ASPI_RESP_SLVERR = 2'b10;

	typedef enum logic [1:0] {
		ASPI_G_ADC,
		ASPI_G_SUP,
		ASPI_G_PT1,
		ASPI_G_PT2
	} aspi_group_t;

endpackage

// File: verilog/aspi_group.sv
/*
 * aspi_group: one interrupt group with enable, flag and request bits.
 * assumes: event inputs are one-cycle or level pulses synchronous to clk_sys_i.
 */
`timescale 1ns/1ps
module aspi_group
	import aspi_pkg::*;
#(
	parameter int WIDTH = 8,
	parameter logic [WIDTH-1:0] FLAG_RST = '0,
	parameter bit FLAG_SW_CLEAR = 1'b1
)
(
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	// register write
	input wire logic wr_i,
	input wire logic [WIDTH-1:0] wr_en_mask_i,
	input wire logic [WIDTH-1:0] wr_mask_i,
	input wire logic [WIDTH-1:0] wr_en_i,
	input wire logic [WIDTH-1:0] wr_flag_i,
	// hardware side
	input wire logic [WIDTH-1:0] event_i,
	input wire logic hw_clear_i,
	// state
	output logic [WIDTH-1:0] enable_o,
	output logic [WIDTH-1:0] flag_o,
	output logic [WIDTH-1:0] request_o
);

	typedef struct packed {
		logic [WIDTH-1:0] en;
		logic [WIDTH-1:0] flag;
	} aspi_grp_state_t;

	aspi_grp_state_t state_ff;
	aspi_grp_state_t nxt_state;

	always_comb
	begin
		nxt_state = state_ff;
		if (wr_i)
		begin
			// enables have their own mask byte, flags theirs
			nxt_state.en = (state_ff.en & ~wr_en_mask_i) | (wr_en_i & wr_en_mask_i);
			// a written zero under a set mask bit clears a flag; hw_clear_i below clears every flag
			if (FLAG_SW_CLEAR)
				nxt_state.flag = state_ff.flag & ~(wr_mask_i & ~wr_flag_i);
		end
		if (hw_clear_i)
			nxt_state.flag = '0;
		// set wins over any clear
		nxt_state.flag = nxt_state.flag | event_i;
	end

	always_ff @(posedge clk_sys_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			state_ff.en <= '0;
			state_ff.flag <= FLAG_RST;
		end
		else
			state_ff <= nxt_state;
	end

	assign enable_o = state_ff.en;
	assign flag_o = state_ff.flag;
	assign request_o = state_ff.flag & state_ff.en;

endmodule

// File: verilog/aspi_axil_slave.sv
/*
 * aspi_axil_slave: AXI4-Lite handshake front end, one write and one read
 * at a time, handing single-cycle register strobes to the core.
 * assumes: the core answers reads combinationally from its state.
 */
`timescale 1ns/1ps
module aspi_axil_slave
	import aspi_pkg::*;
(
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	// write channels
	input wire logic [ASPI_ADDR_W-1:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [ASPI_DATA_W-1:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	// read channels
	input wire logic [ASPI_ADDR_W-1:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [ASPI_DATA_W-1:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	// core side
	output logic wr_o,
	output logic [ASPI_ADDR_W-1:0] wr_addr_o,
	output logic [ASPI_DATA_W-1:0] wr_data_o,
	output logic [3:0] wr_strb_o,
	input wire logic wr_ok_i,
	output logic rd_o,
	output logic [ASPI_ADDR_W-1:0] rd_addr_o,
	input wire logic [ASPI_DATA_W-1:0] rd_data_i,
	input wire logic rd_ok_i
);

	typedef struct packed {
		logic aw_have;
		logic w_have;
		logic [ASPI_ADDR_W-1:0] awaddr;
		logic [ASPI_DATA_W-1:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [ASPI_DATA_W-1:0] rdata;
	} aspi_bus_state_t;

	aspi_bus_state_t st_ff;
	aspi_bus_state_t nxt_st;
	logic aw_take;
	logic w_take;
	logic ar_take;
	logic do_wr;

	assign aw_take = s_axi_awvalid_i && !st_ff.aw_have && !st_ff.bvalid;
	assign w_take = s_axi_wvalid_i && !st_ff.w_have && !st_ff.bvalid;
	assign ar_take = s_axi_arvalid_i && !st_ff.rvalid;
	assign do_wr = st_ff.aw_have && st_ff.w_have;

	always_comb
	begin
		nxt_st = st_ff;
		if (aw_take)
		begin
			nxt_st.aw_have = 1'b1;
			nxt_st.awaddr = s_axi_awaddr_i;
		end
		if (w_take)
		begin
			nxt_st.w_have = 1'b1;
			nxt_st.wdata = s_axi_wdata_i;
			nxt_st.wstrb = s_axi_wstrb_i;
		end
		if (do_wr)
		begin
			nxt_st.aw_have = 1'b0;
			nxt_st.w_have = 1'b0;
			nxt_st.bvalid = 1'b1;
			nxt_st.bresp = wr_ok_i ? ASPI_RESP_OKAY : ASPI_RESP_SLVERR;
		end
		if (st_ff.bvalid && s_axi_bready_i)
			nxt_st.bvalid = 1'b0;
		if (st_ff.rvalid && s_axi_rready_i)
			nxt_st.rvalid = 1'b0;
		if (ar_take)
		begin
			nxt_st.rvalid = 1'b1;
			nxt_st.rdata = rd_ok_i ? rd_data_i : '0;
			nxt_st.rresp = rd_ok_i ? ASPI_RESP_OKAY : ASPI_RESP_SLVERR;
		end
	end

	always_ff @(posedge clk_sys_i or negedge resetn_i)
	begin
		if (!resetn_i)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end

	assign s_axi_awready_o = !st_ff.aw_have && !st_ff.bvalid;
	assign s_axi_wready_o = !st_ff.w_have && !st_ff.bvalid;
	assign s_axi_bvalid_o = st_ff.bvalid;
	assign s_axi_bresp_o = st_ff.bresp;
	assign s_axi_arready_o = !st_ff.rvalid;
	assign s_axi_rvalid_o = st_ff.rvalid;
	assign s_axi_rresp_o = st_ff.rresp;
	assign s_axi_rdata_o = st_ff.rdata;
	assign wr_o = do_wr;
	assign wr_addr_o = st_ff.awaddr;
	assign wr_data_o = st_ff.wdata;
	assign wr_strb_o = st_ff.wstrb;
	assign rd_o = ar_take;
	assign rd_addr_o = s_axi_araddr_i;

endmodule

// File: bench/aspi_core_model.sv
/*
 * aspi_core_model: processor core that takes a vector and enters service.
 * assumes: vector outputs of aspi_top, clocked by the same system clock.
 */
`timescale 1ns/1ps
module aspi_core_model
(
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	// control and vectors
	input wire logic take_en_i,
	input wire logic [3:0] vector_request_i,
	input wire logic [3:0] vector_select_i,
	output logic irq_service_entry_o,
	output logic [3:0] taken_vec_o
);
	always_ff @(posedge clk_sys_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			irq_service_entry_o <= 1'b0;
			taken_vec_o <= 4'h0;
		end
		else
		begin
			// service entry pulse, vector latched when taken
			irq_service_entry_o <= take_en_i && |vector_request_i && !irq_service_entry_o;
			if (take_en_i && |vector_request_i)
				taken_vec_o <= vector_select_i;
		end
	end
endmodule

// File: bench/aspi_top_props.sv
/*
 * aspi_top_props: bus and vector checks on the ports of aspi_top.
 * assumes: bound to every aspi_top instance.
 */
`timescale 1ns/1ps
module aspi_top_props
	import aspi_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	input wire logic s_axi_awvalid_i,
	input wire logic s_axi_awready_o,
	input wire logic s_axi_wvalid_i,
	input wire logic s_axi_wready_o,
	input wire logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [ASPI_ADDR_W-1:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	input wire logic s_axi_arready_o,
	input wire logic [ASPI_DATA_W-1:0] s_axi_rdata_o,
	input wire logic [1:0] s_axi_rresp_o,
	input wire logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	input wire logic irq_service_entry_i,
	input wire logic [3:0] vector_request_o,
	input wire logic [3:0] vector_select_o,
	input wire logic global_irq_enable_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!resetn_i);

	a_vec_needs_gie: assert property (vector_request_o != 4'h0 |-> $past(global_irq_enable_o))
		else $error("vector raised without global enable");
	a_svc_clear: assert property (irq_service_entry_i |=> !global_irq_enable_o)
		else $error("service entry left global enable set");
	a_sel_lowest: assert property (vector_select_o == (vector_request_o & (~vector_request_o + 4'h1)))
		else $error("vector select not lowest request");
	a_wr_answer: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i
		&& s_axi_wready_o |-> ##2 s_axi_bvalid_o)
		else $error("write response late");
	a_b_once: assert property (s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o)
		else $error("write response repeated");
	a_b_busy: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
		else $error("write taken during response");
	a_rd_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o && !s_axi_arready_o)
		else $error("read answer late");
	a_r_once: assert property (s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o)
		else $error("read answer repeated");
	a_rd_unmapped: assert property (s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i == 8'h04
		|=> s_axi_rresp_o == ASPI_RESP_SLVERR && s_axi_rdata_o == 32'h0)
		else $error("unmapped read not refused");
endmodule

bind aspi_top aspi_top_props u_props (.clk_sys_i, .resetn_i, .s_axi_awvalid_i, .s_axi_awready_o,
	.s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i,
	.s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o,
	.s_axi_rready_i, .irq_service_entry_i, .vector_request_o, .vector_select_o,
	.global_irq_enable_o);

// File: bench/tb_aspi_top.sv
/*
 * tb_aspi_top: self-checking bench for the interrupt register block.
 * assumes: aspi_top, aspi_core_model and the bound checker are compiled.
 */
`timescale 1ns/1ps
module tb_aspi_top
	import aspi_pkg::*;
;
	logic clk_sys_i, resetn_i, s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
	logic s_axi_arready_o, s_axi_rvalid_o, global_irq_enable_o, irq_service_entry_i;
	logic s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i;
	logic [7:0] s_axi_awaddr_i, s_axi_araddr_i, port_one_pin_event_i, port_two_pin_event_i;
	logic [31:0] s_axi_wdata_i, s_axi_rdata_o, rd;
	logic [3:0] s_axi_wstrb_i, vector_request_o, vector_select_o, taken_vec;
	logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
	logic conversion_done_i, conversion_result_read_i, low_volt_comparator_out_i;
	logic brownout_two_event_i, take_en;
	logic [19:0] evt;
	int errors, tests_run;

	// event bus: [19:12] port two, [11:4] port one, bor, low volt, result read, done
	assign {port_two_pin_event_i, port_one_pin_event_i, brownout_two_event_i,
		low_volt_comparator_out_i, conversion_result_read_i, conversion_done_i} = evt;

	aspi_top dut (.clk_sys_i, .resetn_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o,
		.s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o,
		.s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o,
		.s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .conversion_done_i,
		.conversion_result_read_i, .low_volt_comparator_out_i, .brownout_two_event_i,
		.port_one_pin_event_i, .port_two_pin_event_i, .irq_service_entry_i, .vector_request_o,
		.vector_select_o, .global_irq_enable_o);
	aspi_core_model core (.clk_sys_i, .resetn_i, .take_en_i(take_en),
		.vector_request_i(vector_request_o), .vector_select_i(vector_select_o),
		.irq_service_entry_o(irq_service_entry_i), .taken_vec_o(taken_vec));

	initial
	begin
		clk_sys_i = 1'b0;
		forever #4 clk_sys_i = ~clk_sys_i;
	end

	task automatic print_verdict();
		$display("errors %0d tests_run %0d", errors, tests_run);
		if (errors == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp)
		begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge clk_sys_i);
		s_axi_awaddr_i <= a;
		s_axi_wdata_i <= d;
		s_axi_awvalid_i <= 1'b1;
		s_axi_wvalid_i <= 1'b1;
		s_axi_bready_i <= 1'b1;
		do
		begin
			@(posedge clk_sys_i);
			if (s_axi_awready_o)
				s_axi_awvalid_i <= 1'b0;
			if (s_axi_wready_o)
				s_axi_wvalid_i <= 1'b0;
		end while (!s_axi_bvalid_o);
		s_axi_bready_i <= 1'b0;
		chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp_o});
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
		@(posedge clk_sys_i);
		s_axi_araddr_i <= a;
		s_axi_arvalid_i <= 1'b1;
		s_axi_rready_i <= 1'b1;
		do
		begin
			@(posedge clk_sys_i);
			if (s_axi_arready_o)
				s_axi_arvalid_i <= 1'b0;
		end while (!s_axi_rvalid_o);
		rd = s_axi_rdata_o;
		s_axi_rready_i <= 1'b0;
		chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp_o});
		chk("rdata", exp, rd);
	endtask

	task automatic pls(input logic [19:0] v);
		@(posedge clk_sys_i);
		evt <= v;
		@(posedge clk_sys_i);
		evt <= 20'h0;
	endtask

	task automatic t_converter();
		axw(8'h08, 32'h0101_0000, ASPI_RESP_OKAY);
		pls(20'h00001);
		rdc(8'h08, 32'h0001_0101, ASPI_RESP_OKAY);
		axw(8'h08, 32'h0100_0100, ASPI_RESP_OKAY);
		rdc(8'h08, 32'h0000_0001, ASPI_RESP_OKAY);
		pls(20'h00002);
		rdc(8'h08, 32'h0000_0000, ASPI_RESP_OKAY);
	endtask

	task automatic t_supply();
		axw(8'h0C, 32'h0303_0000, ASPI_RESP_OKAY);
		pls(20'h0000C);
		rdc(8'h0C, 32'h0003_0303, ASPI_RESP_OKAY);
		axw(8'h0C, 32'h0000_0200, ASPI_RESP_OKAY);
		rdc(8'h0C, 32'h0003_0101, ASPI_RESP_OKAY);
		axw(8'h0C, 32'h0000_0100, ASPI_RESP_OKAY);
		rdc(8'h0C, 32'h0003_0000, ASPI_RESP_OKAY);
		pls(20'h00004);
	endtask

	task automatic t_ports();
		for (int i = 0; i < 2; i++)
		begin
			axw(8'h10 + 8'(4 * i), 32'hFFA5_FF00, ASPI_RESP_OKAY);
			pls(i == 0 ? 20'h00FF0 : 20'hFF000);
			rdc(8'h10 + 8'(4 * i), 32'h00A5_A5FF, ASPI_RESP_OKAY);
			axw(8'h10 + 8'(4 * i), 32'h0000_0F00, ASPI_RESP_OKAY);
			axw(8'h10 + 8'(4 * i), 32'h00FF_0000, ASPI_RESP_OKAY);
			rdc(8'h10 + 8'(4 * i), 32'h00A5_A0F0, ASPI_RESP_OKAY);
		end
	endtask

	task automatic t_vectors();
		chk("vector_request", 32'h0, {28'h0, vector_request_o});
		axw(ASPI_OFS_GIE, 32'h0000_0001, ASPI_RESP_OKAY);
		chk("global_irq_enable", 32'h1, {31'h0, global_irq_enable_o});
		repeat (3) @(posedge clk_sys_i);
		chk("vector_request", 32'hE, {28'h0, vector_request_o});
		chk("vector_select", 32'h2, {28'h0, vector_select_o});
		rdc(ASPI_OFS_GIE, 32'h1, ASPI_RESP_OKAY);
		take_en <= 1'b1;
		repeat (6) @(posedge clk_sys_i);
		take_en <= 1'b0;
		chk("taken_vector", 32'h2, {28'h0, taken_vec});
		chk("vector_request", 32'h0, {28'h0, vector_request_o});
		chk("global_irq_enable", 32'h0, {31'h0, global_irq_enable_o});
		rdc(ASPI_OFS_GIE, 32'h0, ASPI_RESP_OKAY);
	endtask

	initial
	begin
		{s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i} = '0;
		s_axi_awaddr_i = 8'h00;
		s_axi_araddr_i = 8'h00;
		s_axi_wdata_i = 32'h0;
		s_axi_wstrb_i = 4'hF;
		evt = 20'h0;
		take_en = 1'b0;
		errors = 0;
		tests_run = 0;
		resetn_i = 1'b0;
		repeat (5) @(posedge clk_sys_i);
		resetn_i <= 1'b1;
		for (int i = 0; i < 4; i++)
			rdc(8'h08 + 8'(4 * i), 32'h0, ASPI_RESP_OKAY);
		t_converter();
		t_supply();
		t_ports();
		t_vectors();
		rdc(8'h04, 32'h0, ASPI_RESP_SLVERR);
		axw(8'h1C, 32'h00FF_FF00, ASPI_RESP_SLVERR);
		print_verdict();
	end

	initial
	begin
		repeat (5000) @(posedge clk_sys_i);
		errors++;
		print_verdict();
	end
endmodule
